// ### src/ups_pkg.sv
// Package for the upload packet status block: register map, field layout,
// reset values and enumerations.
// Assumes a single ref_clk domain and a synchronous active-high reset.
package ups_pkg;

  // Register offsets (byte addresses)
  localparam logic [7:0] UPS_STATUS_OFS = 8'h30;
  localparam logic [7:0] UPS_INT_STAT_OFS = 8'h34;
  localparam logic [7:0] UPS_INT_MASK_OFS = 8'h38;
  localparam logic [7:0] UPS_CMD_OFS = 8'h3C;

  // Status word field positions
  localparam int UPS_LEN_LSB = 0;
  localparam int UPS_LEN_W = 15;
  localparam int UPS_STALL_BIT = 15;
  localparam int UPS_MATCH_LSB = 16;
  localparam int UPS_OVR_BIT = 19;
  localparam int UPS_RSVD_BIT = 20;
  localparam int UPS_FC_BIT = 21;
  localparam int UPS_AR_BIT = 22;
  localparam int UPS_DONE_BIT = 23;
  localparam int UPS_NEED_BIT = 24;
  localparam int UPS_CODE_LSB = 25;

  // Command register bits (write one to execute)
  localparam int UPS_CMD_STALL_BIT = 0;
  localparam int UPS_CMD_UNSTALL_BIT = 1;
  localparam int UPS_CMD_DISCARD_BIT = 2;

  // Interrupt status bits
  localparam int UPS_IRQ_W = 4;
  localparam int UPS_IRQ_DONE = 0;
  localparam int UPS_IRQ_NEED = 1;
  localparam int UPS_IRQ_OVR = 2;
  localparam int UPS_IRQ_STALL = 3;

  // Reset values
  localparam logic [31:0] UPS_STATUS_RST = 32'h0000_0000;
  localparam logic [3:0] UPS_IRQ_RST = 4'h0;

  // Address slot match codes
  typedef enum logic [2:0] {
    UPS_SLOT_NODE = 3'h0,
    UPS_SLOT_NODE_MAC = 3'h4,
    UPS_SLOT_SRC_ROUTE = 3'h5,
    UPS_SLOT_FUNCTIONAL = 3'h7
  } ups_slot_type;

  // Receive outcome codes
  typedef enum logic [1:0] {
    UPS_RX_OK = 2'h0,
    UPS_RX_ABORT = 2'h1,
    UPS_RX_IMPLICIT_ABORT = 2'h2,
    UPS_RX_FS_MISMATCH = 2'h3
  } ups_outcome_type;

endpackage

// ### src/ups_regs.sv
// Register port slave for the upload packet status block.
// Assumes the master keeps strobes one cycle long and never both at once.
module ups_regs (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [31:0] status_word,
  input wire logic [ups_pkg::UPS_IRQ_W-1:0] irq_events,
  output logic [31:0] rdata,
  output logic [ups_pkg::UPS_IRQ_W-1:0] cmd_pulse,
  output logic irq
);
  logic [31:0] rdata_q;
  logic [ups_pkg::UPS_IRQ_W-1:0] stat_q;
  logic [ups_pkg::UPS_IRQ_W-1:0] stat_d;
  logic [ups_pkg::UPS_IRQ_W-1:0] mask_q;
  logic irq_q;
  logic [ups_pkg::UPS_IRQ_W-1:0] cmd_q;

  // Address decode
  wire sel_status = (addr == ups_pkg::UPS_STATUS_OFS);
  wire sel_stat = (addr == ups_pkg::UPS_INT_STAT_OFS);
  wire sel_mask = (addr == ups_pkg::UPS_INT_MASK_OFS);
  wire sel_cmd = (addr == ups_pkg::UPS_CMD_OFS);
  wire [ups_pkg::UPS_IRQ_W-1:0] w1c =
      (wr_stb && sel_stat) ? wdata[ups_pkg::UPS_IRQ_W-1:0] : '0;
  wire [31:0] rd_mux =
      sel_status ? status_word :
      sel_stat ? {28'h0, stat_q} :
      sel_mask ? {28'h0, mask_q} : 32'h0;

  // Sticky status: a new event wins over a same-cycle clear
  assign stat_d = (stat_q & ~w1c) | irq_events;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rdata_q <= 32'h0;
      stat_q <= ups_pkg::UPS_IRQ_RST;
      mask_q <= ups_pkg::UPS_IRQ_RST;
      irq_q <= 1'b0;
      cmd_q <= '0;
    end else begin
      rdata_q <= rd_stb ? rd_mux : 32'h0;
      stat_q <= stat_d;
      if (wr_stb && sel_mask) begin
        mask_q <= wdata[ups_pkg::UPS_IRQ_W-1:0];
      end
      irq_q <= |(stat_d & mask_q);
      cmd_q <= (wr_stb && sel_cmd) ? wdata[ups_pkg::UPS_IRQ_W-1:0] : '0;
    end
  end

  assign rdata = rdata_q;
  assign irq = irq_q;
  assign cmd_pulse = cmd_q;
endmodule

// ### src/ups_status.sv
// Upload packet status word of a receive-upload bus-master engine.
// Assumes the MAC, buffer manager and descriptor walker supply one-cycle
// event pulses synchronous to ref_clk; the status word is read-only.
//
// The implementer's own choices: the placing of the registers and strobed register access.

// Contract
// - Length field counts uploaded bytes while reception is in progress.
// - After reception finishes, length field holds total received size.
// - Bit 15 reads one exactly while the engine is stalled.
// - Stall on command, or on a used descriptor when not polling.
// - Only an unstall command clears the stall; host must issue it.
// - Bits 18:16 hold matched slot: 000, 100, 101 or 111.
// - Bit 19 set on buffer space shortage or byte limit exceeded.
// - On overrun only upload completion is meaningful.
// - Bit 21 copies frame-copied indicator from frame status.
// - Bit 22 copies address-recognized indicator from frame status.
// - Bit 23 set when packet upload to host memory finishes.
// - Bit 24 set when descriptor needed but list empty or descriptor used.
// - Descriptor need stalls upload while frame keeps collecting on-card.
// - Need bit held until discard clears it; interrupt copy stays sticky past discard.
// - Bits 26:25 code 00 normal, 01 aborted packet.
// - Code 10 implicit abort, 11 frame status pair mismatch.
// - Discard after status write-back zeroes the status word except stall bit 15.
module ups_status #(
  parameter int LEN_W = 15
) (
  input wire logic ref_clk,
  input wire logic srst,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rdata,
  output logic irq,
  // Upload datapath events
  input wire logic byte_uploaded,
  input wire logic rx_done,
  input wire logic [LEN_W-1:0] rx_total_len,
  input wire logic upload_done,
  input wire logic upload_halt_req,
  input wire logic desc_fetch,
  input wire logic desc_done_or_full,
  input wire logic polling_on,
  input wire logic desc_need,
  input wire logic list_empty,
  input wire logic buf_space_short,
  input wire logic byte_limit_hit,
  input wire logic [2:0] slot_match,
  input wire logic match_valid,
  input wire logic fs_valid,
  input wire logic [1:0] fs_ar_pair,
  input wire logic [1:0] fs_fc_pair,
  input wire logic explicit_abort,
  input wire logic implicit_abort,
  input wire logic discard_req,
  // Status towards the engine and write-back path
  output logic upload_halted_flag,
  output logic [31:0] writeback_word
);
  logic [LEN_W-1:0] len_q;
  logic [LEN_W-1:0] len_d;
  logic rx_fin_q;
  logic halt_q;
  logic [2:0] slot_q;
  logic ovr_q;
  logic fc_q;
  logic ar_q;
  logic done_q;
  logic need_q;
  logic [1:0] code_q;
  logic [1:0] code_d;
  logic [31:0] word_q;
  logic [31:0] status_word;
  logic [31:0] word_d;
  logic [ups_pkg::UPS_IRQ_W-1:0] cmd_pulse;
  logic [ups_pkg::UPS_IRQ_W-1:0] irq_events;

  // Decoded commands from the register port and the engine
  wire cmd_halt = cmd_pulse[ups_pkg::UPS_CMD_STALL_BIT];
  wire cmd_resume = cmd_pulse[ups_pkg::UPS_CMD_UNSTALL_BIT];
  wire cmd_drop = cmd_pulse[ups_pkg::UPS_CMD_DISCARD_BIT] | discard_req;

  // Stall causes: command, used descriptor with polling off, or need
  wire implicit_halt = desc_fetch && desc_done_or_full && !polling_on;
  wire need_event = desc_need && (list_empty || desc_done_or_full);
  wire halt_set = upload_halt_req || cmd_halt || implicit_halt || need_event;
  wire overrun_event = buf_space_short || byte_limit_hit;

  // Frame status pair mismatch: each indicator is sent twice
  wire fs_mismatch = (fs_ar_pair[1] != fs_ar_pair[0]) ||
                     (fs_fc_pair[1] != fs_fc_pair[0]);

  // Length: running count until reception ends, then the total
  assign len_d = rx_done ? rx_total_len :
                 (byte_uploaded && !rx_fin_q) ?
                 LEN_W'(len_q + 1'b1) : len_q;

  // Outcome code with severity priority
  assign code_d = (fs_valid && fs_mismatch) ?
                  ups_pkg::UPS_RX_FS_MISMATCH :
                  implicit_abort ? ups_pkg::UPS_RX_IMPLICIT_ABORT :
                  explicit_abort ? ups_pkg::UPS_RX_ABORT : code_q;

  // Assembled word; bit 20 is tied low
  always_comb begin
    status_word = ups_pkg::UPS_STATUS_RST;
    status_word[ups_pkg::UPS_LEN_LSB +: ups_pkg::UPS_LEN_W] =
        ups_pkg::UPS_LEN_W'(len_q);
    status_word[ups_pkg::UPS_STALL_BIT] = halt_q;
    status_word[ups_pkg::UPS_MATCH_LSB +: 3] = slot_q;
    status_word[ups_pkg::UPS_OVR_BIT] = ovr_q;
    status_word[ups_pkg::UPS_RSVD_BIT] = 1'b0;
    status_word[ups_pkg::UPS_FC_BIT] = fc_q;
    status_word[ups_pkg::UPS_AR_BIT] = ar_q;
    status_word[ups_pkg::UPS_DONE_BIT] = done_q;
    status_word[ups_pkg::UPS_NEED_BIT] = need_q;
    status_word[ups_pkg::UPS_CODE_LSB +: 2] = code_q;
  end

  // Write-back image: word at upload end, finished bit already included
  assign word_d = upload_done ?
                  (status_word | (32'h1 << ups_pkg::UPS_DONE_BIT)) :
                  word_q;

  // Interrupt events; the need copy here stays until acknowledged
  assign irq_events[ups_pkg::UPS_IRQ_DONE] = upload_done;
  assign irq_events[ups_pkg::UPS_IRQ_NEED] = need_event;
  assign irq_events[ups_pkg::UPS_IRQ_OVR] = overrun_event;
  assign irq_events[ups_pkg::UPS_IRQ_STALL] = halt_set && !halt_q;

  // Stall flag: set by any cause, cleared only by resume; set wins
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      halt_q <= 1'b0;
    end else if (halt_set) begin
      halt_q <= 1'b1;
    end else if (cmd_resume) begin
      halt_q <= 1'b0;
    end
  end

  // Per-packet fields; discard zeroes the word except the stall bit
  always_ff @(posedge ref_clk) begin
    if (srst || cmd_drop) begin
      len_q <= '0;
      rx_fin_q <= 1'b0;
      slot_q <= ups_pkg::UPS_SLOT_NODE;
      ovr_q <= 1'b0;
      fc_q <= 1'b0;
      ar_q <= 1'b0;
      done_q <= 1'b0;
      need_q <= 1'b0;
      code_q <= ups_pkg::UPS_RX_OK;
    end else begin
      len_q <= len_d;
      rx_fin_q <= rx_fin_q | rx_done;
      if (match_valid) begin
        slot_q <= slot_match;
      end
      ovr_q <= ovr_q | overrun_event;
      if (fs_valid) begin
        fc_q <= fs_fc_pair[0];
        ar_q <= fs_ar_pair[0];
      end
      done_q <= done_q | upload_done;
      need_q <= need_q | need_event;
      code_q <= code_d;
    end
  end

  // Write-back word register for the descriptor frame state entry
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      word_q <= ups_pkg::UPS_STATUS_RST;
    end else begin
      word_q <= word_d;
    end
  end

  // Register port; the status word offset ignores writes
  ups_regs u_regs (
    .ref_clk(ref_clk),
    .srst(srst),
    .addr(addr),
    .wdata(wdata),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb),
    .status_word(status_word),
    .irq_events(irq_events),
    .rdata(rdata),
    .cmd_pulse(cmd_pulse),
    .irq(irq)
  );

  assign upload_halted_flag = halt_q;
  assign writeback_word = word_q;
endmodule

// ### verification/upload_packet_status_tb_top.sv
// Bench for the upload packet status block: pulses events, reads status.
// Assumes read data one cycle after the strobe and commands at 0x3C.
module upload_packet_status_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic wr_stb = 1'b0, rd_stb = 1'b0, dfull = 1'b0, poll = 1'b0;
  logic refill = 1'b0, irq, halted, empty;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, v, wb;
  logic [12:0] pl = 13'h0;
  logic [14:0] tlen = 15'h0;
  logic [2:0] slot = 3'h0;
  logic [1:0] ar = 2'h0, fc = 2'h0;
  int err_count = 0, cmp_count = 0;
  always #50 ref_clk = ~ref_clk;
  ups_status i_ups_status (.ref_clk(ref_clk), .srst(srst), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .irq(irq), .byte_uploaded(pl[0]), .rx_done(pl[1]), .rx_total_len(tlen),
    .upload_done(pl[2]), .upload_halt_req(pl[3]), .desc_fetch(pl[4]),
    .desc_done_or_full(dfull), .polling_on(poll), .desc_need(pl[5]),
    .list_empty(empty), .buf_space_short(pl[6]), .byte_limit_hit(pl[7]),
    .slot_match(slot), .match_valid(pl[8]), .fs_valid(pl[9]),
    .fs_ar_pair(ar), .fs_fc_pair(fc), .explicit_abort(pl[10]),
    .implicit_abort(pl[11]), .discard_req(pl[12]),
    .upload_halted_flag(halted), .writeback_word(wb));
  ups_host_model i_ups_host_model (.ref_clk(ref_clk), .srst(srst),
    .refill(refill), .list_empty(empty));
  // Compare, bus cycles and event pulses
  task automatic chk(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    wr_stb <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    rd_stb <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic st(input logic [31:0] m, e);
    rd(ups_pkg::UPS_STATUS_OFS);
    chk(v & m, e);
  endtask
  task automatic ev(input logic [12:0] m);
    @(posedge ref_clk);
    pl <= m;
    @(posedge ref_clk);
    pl <= 13'h0;
  endtask
  task automatic t_len();
    rd(8'h00);
    chk(v, 32'h0);
    st(32'hFFFFFFFF, ups_pkg::UPS_STATUS_RST);
    repeat (3) ev(13'h1);
    st(32'h7FFF, 32'h3);
    tlen <= 15'h5A5A;
    ev(13'h2);
    ev(13'h1);
    st(32'h7FFF, 32'h5A5A);
    $display("length test done");
  endtask
  task automatic t_halt();
    wr(ups_pkg::UPS_CMD_OFS, 32'h1);
    wr(ups_pkg::UPS_CMD_OFS, 32'h4);
    st(32'h8000, 32'h8000);
    wr(ups_pkg::UPS_CMD_OFS, 32'h2);
    st(32'h8000, 32'h0);
    dfull <= 1'b1;
    ev(13'h10);
    st(32'h8000, 32'h8000);
    wr(ups_pkg::UPS_CMD_OFS, 32'h2);
    poll <= 1'b1;
    ev(13'h10);
    st(32'h8000, 32'h0);
    ev(13'h8);
    st(32'h8000, 32'h8000);
    wr(ups_pkg::UPS_CMD_OFS, 32'h2);
    dfull <= 1'b0;
    $display("halt test done");
  endtask
  task automatic t_fields();
    logic [2:0] codes [4] = '{3'h0, 3'h4, 3'h5, 3'h7};
    foreach (codes[i]) begin
      slot <= codes[i];
      ev(13'h100);
      st(32'h70000, {13'h0, codes[i], 16'h0});
    end
    ev(13'h1000);
    ar <= 2'h3;
    fc <= 2'h3;
    ev(13'h200);
    st(32'h6600000, 32'h600000);
    ev(13'h400);
    st(32'h6000000, 32'h2000000);
    ev(13'h1000);
    ev(13'h800);
    st(32'h6000000, 32'h4000000);
    ev(13'h1000);
    ar <= 2'h2;
    ev(13'h200);
    st(32'h6600000, 32'h6200000);
    ev(13'h1040);
    ev(13'h80);
    st(32'h80000, 32'h80000);
    ev(13'h4);
    st(32'h880000, 32'h880000);
    chk(wb, 32'h880000);
    ev(13'h1000);
    st(32'hFFFFFFFF, 32'h0);
    wr(ups_pkg::UPS_STATUS_OFS, 32'hFFFFFFFF);
    st(32'hFFFFFFFF, 32'h0);
    $display("field test done");
  endtask
  task automatic t_need();
    wr(ups_pkg::UPS_INT_MASK_OFS, 32'h2);
    ev(13'h20);
    st(32'h1008000, 32'h1008000);
    chk({31'h0, irq}, 32'h1);
    wr(ups_pkg::UPS_CMD_OFS, 32'h4);
    st(32'h1000000, 32'h0);
    rd(ups_pkg::UPS_INT_STAT_OFS);
    chk(v & 32'h2, 32'h2);
    wr(ups_pkg::UPS_INT_STAT_OFS, 32'h2);
    rd(ups_pkg::UPS_INT_MASK_OFS);
    chk({31'h0, irq}, 32'h0);
    wr(ups_pkg::UPS_CMD_OFS, 32'h2);
    refill <= 1'b1;
    ev(13'h20);
    refill <= 1'b0;
    st(32'h1008000, 32'h0);
    $display("need test done");
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Watchdog cuts a hang short
  initial begin
    #200000;
    err_count++;
    end_of_test();
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    srst <= 1'b0;
    t_len();
    t_halt();
    t_fields();
    t_need();
    end_of_test();
  end
endmodule

// ### verification/ups_host_model.sv
// Host side model: descriptor list state seen by the upload engine.
// Assumes the bench supplies descriptors by a two-cycle refill pulse.
module ups_host_model (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic refill,
  output logic list_empty
);
  timeunit 1ns;
  timeprecision 1ns;
  // List starts empty, the host fills it with fragments
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      list_empty <= 1'b1;
    end else if (refill) begin
      list_empty <= 1'b0;
    end
  end
endmodule

// ### verification/ups_status_assertions.sv
// Checker for the upload packet status block, bound to its top module.
// Assumes one clock domain and the register map of the block package.
module ups_status_checker (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [31:0] rdata,
  input wire logic upload_halt_req,
  input wire logic desc_need,
  input wire logic list_empty,
  input wire logic buf_space_short,
  input wire logic byte_limit_hit,
  input wire logic upload_done,
  input wire logic fs_valid,
  input wire logic [1:0] fs_ar_pair,
  input wire logic discard_req,
  input wire logic upload_halted_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  // Status read and resume command decodes
  wire st_sel = addr == ups_pkg::UPS_STATUS_OFS;
  wire cmd_sel = addr == ups_pkg::UPS_CMD_OFS;
  wire resume_wr = wr_stb && cmd_sel && wdata[1];
  sequence st_rd;
    rd_stb && st_sel;
  endsequence
  halt_cmd_a: assert property (upload_halt_req |=> upload_halted_flag)
    else $error("halt request ignored");
  halt_clear_a: assert property (
    $fell(upload_halted_flag) && !$past(srst) |-> $past(resume_wr, 2))
    else $error("halt cleared without resume");
  halt_bit_a: assert property (
    st_rd |=> rdata[15] == $past(upload_halted_flag))
    else $error("halt bit differs from flag");
  rsvd_zero_a: assert property (st_rd |=> !rdata[20])
    else $error("bit 20 not zero");
  done_bit_a: assert property (
    upload_done && !discard_req ##2 st_rd |=> rdata[23])
    else $error("finished bit missing");
  need_bit_a: assert property (
    desc_need && list_empty && !discard_req ##2 st_rd
      |=> rdata[24] && rdata[15])
    else $error("need bit or halt missing");
  ovr_bit_a: assert property (
    (buf_space_short || byte_limit_hit) && !discard_req ##2 st_rd
      |=> rdata[19])
    else $error("overflow bit missing");
  ar_bit_a: assert property (
    fs_valid && !discard_req ##2 st_rd
      |=> rdata[22] == $past(fs_ar_pair[0], 3))
    else $error("recognized bit wrong");
endmodule

bind ups_status ups_status_checker i_ups_status_checker (
  .ref_clk(ref_clk), .srst(srst), .addr(addr), .wdata(wdata),
  .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
  .upload_halt_req(upload_halt_req), .desc_need(desc_need),
  .list_empty(list_empty), .buf_space_short(buf_space_short),
  .byte_limit_hit(byte_limit_hit), .upload_done(upload_done),
  .fs_valid(fs_valid), .fs_ar_pair(fs_ar_pair), .discard_req(discard_req),
  .upload_halted_flag(upload_halted_flag));
